/* File: verilog/irq_mask_pkg.sv */
// constants for the charger interrupt mask bank
package irq_mask_pkg;
  localparam logic [7:0] ADDR_MASK_A  = 8'h08;
  localparam logic [7:0] ADDR_MASK_B  = 8'h09;
  localparam logic [7:0] ADDR_MASK_C  = 8'h0a;
  localparam logic [7:0] RESET_MASK_A = 8'h00;
  localparam logic [7:0] RESET_MASK_B = 8'h71;
  localparam logic [7:0] RESET_MASK_C = 8'h00;
  localparam int         NUM_REGS     = 3;
  localparam int         REG_WIDTH    = 8;
  // first flag index of each register's sources
  localparam int         SRC_BASE_A                = 0;
  localparam int         SRC_BASE_B                = 8;
  localparam int         SRC_BASE_C                = 16;
  // field positions, first register
  localparam int         BIT_INPUT_OVERVOLTAGE     = 7;
  localparam int         BIT_RESERVED_A            = 6;
  localparam int         BIT_BATTERY_OVERCURRENT   = 5;
  localparam int         BIT_BATTERY_UNDERVOLTAGE  = 4;
  localparam int         BIT_THERMISTOR_COLD       = 3;
  localparam int         BIT_THERMISTOR_COOL       = 2;
  localparam int         BIT_THERMISTOR_WARM       = 1;
  localparam int         BIT_THERMISTOR_HOT        = 0;
  // field positions, second register
  localparam int         BIT_CONVERSION_READY      = 7;
  localparam int         BIT_COMPARATOR_ONE        = 6;
  localparam int         BIT_COMPARATOR_TWO        = 5;
  localparam int         BIT_COMPARATOR_THREE      = 4;
  localparam int         BIT_RESERVED_B_HI         = 3;
  localparam int         BIT_RESERVED_B_LO         = 1;
  localparam int         BIT_THERMISTOR_OPEN       = 0;
  // field positions, third register
  localparam int         BIT_RESERVED_C_HI         = 7;
  localparam int         BIT_WATCHDOG_FAULT        = 6;
  localparam int         BIT_SAFETY_TIMER_FAULT    = 5;
  localparam int         BIT_REGULATOR_OVERCURRENT = 4;
  localparam int         BIT_RESERVED_C_LO         = 3;
  localparam int         BIT_BUTTON_WAKE_ONE       = 2;
  localparam int         BIT_BUTTON_WAKE_TWO       = 1;
  localparam int         BIT_BUTTON_RESET_WARNING  = 0;
endpackage : irq_mask_pkg

/* File: verilog/irq_mask_reg.sv */
// one 8-bit read/write mask register
`timescale 1ns/1ps
module irq_mask_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       write_en,
  input  wire logic [7:0] write_data,
  output logic      [7:0] value
);
  logic [7:0] value_ff;
  logic [7:0] nxt_value;

  always_comb begin
    nxt_value = write_en ? write_data : value_ff;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      value_ff <= RESET_VALUE;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;
endmodule : irq_mask_reg

/* File: verilog/charger_interrupt_mask_bank.sv */
// mask bank: three mask registers, flag capture and masked interrupt requests
`timescale 1ns/1ps
module charger_interrupt_mask_bank (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [23:0] event_in,
  input  wire logic [23:0] flag_clear,
  output logic      [23:0] event_flags,
  output logic      [23:0] irq_request,
  output logic             irq_any
);
  ////////////////////////////////////////////////////////////////////////////////
  // mask registers
  logic [7:0] mask_a;
  logic [7:0] mask_b;
  logic [7:0] mask_c;
  logic [2:0] wr_sel;

  function automatic logic [2:0] decode(input logic [7:0] addr);
    decode = 3'h0;
    if (addr == irq_mask_pkg::ADDR_MASK_A) decode = 3'h1;
    if (addr == irq_mask_pkg::ADDR_MASK_B) decode = 3'h2;
    if (addr == irq_mask_pkg::ADDR_MASK_C) decode = 3'h4;
  endfunction : decode

  assign wr_sel = reg_write ? decode(reg_addr) : 3'h0;

  // all bits including reserved ones are plain read/write
  irq_mask_reg #(.RESET_VALUE(irq_mask_pkg::RESET_MASK_A)) u_mask_a (
    .clock      (clock),
    .reset      (reset),
    .write_en   (wr_sel[0]),
    .write_data (reg_wdata),
    .value      (mask_a)
  );
  irq_mask_reg #(.RESET_VALUE(irq_mask_pkg::RESET_MASK_B)) u_mask_b (
    .clock      (clock),
    .reset      (reset),
    .write_en   (wr_sel[1]),
    .write_data (reg_wdata),
    .value      (mask_b)
  );
  irq_mask_reg #(.RESET_VALUE(irq_mask_pkg::RESET_MASK_C)) u_mask_c (
    .clock      (clock),
    .reset      (reset),
    .write_en   (wr_sel[2]),
    .write_data (reg_wdata),
    .value      (mask_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // named fields, watched by the gate checks and the reserved-bit read/write checks
  logic       input_overvoltage_mask;
  logic       reserved_a_bit;
  logic       battery_overcurrent_mask;
  logic       battery_undervoltage_mask;
  logic       thermistor_cold_mask;
  logic       thermistor_cool_mask;
  logic       thermistor_warm_mask;
  logic       thermistor_hot_mask;
  logic       conversion_ready_mask;
  logic       comparator_one_alarm_mask;
  logic       comparator_two_alarm_mask;
  logic       comparator_three_alarm_mask;
  logic [2:0] reserved_b_field;
  logic       thermistor_open_mask;
  logic       reserved_c_hi_bit;
  logic       watchdog_fault_mask;
  logic       safety_timer_fault_mask;
  logic       regulator_overcurrent_mask;
  logic       reserved_c_lo_bit;
  logic       button_wake_one_mask;
  logic       button_wake_two_mask;
  logic       button_reset_warning_mask;

  assign input_overvoltage_mask      = mask_a[irq_mask_pkg::BIT_INPUT_OVERVOLTAGE];
  assign reserved_a_bit              = mask_a[irq_mask_pkg::BIT_RESERVED_A];
  assign battery_overcurrent_mask    = mask_a[irq_mask_pkg::BIT_BATTERY_OVERCURRENT];
  assign battery_undervoltage_mask   = mask_a[irq_mask_pkg::BIT_BATTERY_UNDERVOLTAGE];
  assign thermistor_cold_mask        = mask_a[irq_mask_pkg::BIT_THERMISTOR_COLD];
  assign thermistor_cool_mask        = mask_a[irq_mask_pkg::BIT_THERMISTOR_COOL];
  assign thermistor_warm_mask        = mask_a[irq_mask_pkg::BIT_THERMISTOR_WARM];
  assign thermistor_hot_mask         = mask_a[irq_mask_pkg::BIT_THERMISTOR_HOT];
  assign conversion_ready_mask       = mask_b[irq_mask_pkg::BIT_CONVERSION_READY];
  assign comparator_one_alarm_mask   = mask_b[irq_mask_pkg::BIT_COMPARATOR_ONE];
  assign comparator_two_alarm_mask   = mask_b[irq_mask_pkg::BIT_COMPARATOR_TWO];
  assign comparator_three_alarm_mask = mask_b[irq_mask_pkg::BIT_COMPARATOR_THREE];
  assign reserved_b_field            = mask_b[irq_mask_pkg::BIT_RESERVED_B_HI:
                                              irq_mask_pkg::BIT_RESERVED_B_LO];
  assign thermistor_open_mask        = mask_b[irq_mask_pkg::BIT_THERMISTOR_OPEN];
  assign reserved_c_hi_bit           = mask_c[irq_mask_pkg::BIT_RESERVED_C_HI];
  assign watchdog_fault_mask         = mask_c[irq_mask_pkg::BIT_WATCHDOG_FAULT];
  assign safety_timer_fault_mask     = mask_c[irq_mask_pkg::BIT_SAFETY_TIMER_FAULT];
  assign regulator_overcurrent_mask  = mask_c[irq_mask_pkg::BIT_REGULATOR_OVERCURRENT];
  assign reserved_c_lo_bit           = mask_c[irq_mask_pkg::BIT_RESERVED_C_LO];
  assign button_wake_one_mask        = mask_c[irq_mask_pkg::BIT_BUTTON_WAKE_ONE];
  assign button_wake_two_mask        = mask_c[irq_mask_pkg::BIT_BUTTON_WAKE_TWO];
  assign button_reset_warning_mask   = mask_c[irq_mask_pkg::BIT_BUTTON_RESET_WARNING];

  ////////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped reads zero
  always_comb begin
    unique case (decode(reg_addr))
      3'h1:    reg_rdata = mask_a;
      3'h2:    reg_rdata = mask_b;
      3'h4:    reg_rdata = mask_c;
      default: reg_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags: set regardless of mask, set wins over clear
  logic [23:0] flags_ff;
  logic [23:0] nxt_flags;
  logic [23:0] mask_all;

  assign mask_all = {mask_c, mask_b, mask_a};

  always_comb begin
    nxt_flags = (flags_ff & ~flag_clear) | event_in;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flags_ff <= 24'h00_0000;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign event_flags = flags_ff;
  assign irq_request = flags_ff & ~mask_all;
  assign irq_any     = |irq_request;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_reset_values: assert property (@(posedge clock)
    reset |=> (mask_a == irq_mask_pkg::RESET_MASK_A && mask_b == irq_mask_pkg::RESET_MASK_B
      && mask_c == irq_mask_pkg::RESET_MASK_C))
    else $error("mask reset values wrong");
  a_reset_b_value: assert property (@(posedge clock)
    reset |=> (reg_addr != irq_mask_pkg::ADDR_MASK_B || reg_rdata == irq_mask_pkg::RESET_MASK_B))
    else $error("second mask read after reset wrong");
  a_write_a_takes: assert property (@(posedge clock) disable iff (reset)
    (reg_write && reg_addr == irq_mask_pkg::ADDR_MASK_A) |=> mask_a == $past(reg_wdata))
    else $error("first mask write lost");
  a_write_b_takes: assert property (@(posedge clock) disable iff (reset)
    (reg_write && reg_addr == irq_mask_pkg::ADDR_MASK_B) |=> mask_b == $past(reg_wdata))
    else $error("second mask write lost");
  a_write_c_takes: assert property (@(posedge clock) disable iff (reset)
    (reg_write && reg_addr == irq_mask_pkg::ADDR_MASK_C) |=> mask_c == $past(reg_wdata))
    else $error("third mask write lost");
  a_mask_blocks: assert property (@(posedge clock) disable iff (reset)
    (mask_a[7] |-> !irq_request[7]) and (!mask_a[7] && flags_ff[7] |-> irq_request[7]))
    else $error("mask polarity wrong");
  a_flag_recorded: assert property (@(posedge clock) disable iff (reset)
    event_in[16] |=> event_flags[16])
    else $error("event lost while masked");
  a_hold_no_write: assert property (@(posedge clock) disable iff (reset)
    !reg_write |=> $stable(mask_b))
    else $error("mask changed without write");
  a_overvoltage_gate: assert property (@(posedge clock) disable iff (reset)
    input_overvoltage_mask |-> !irq_request[irq_mask_pkg::BIT_INPUT_OVERVOLTAGE])
    else $error("input overvoltage request not masked");
  a_bat_current_gate: assert property (@(posedge clock) disable iff (reset)
    battery_overcurrent_mask |-> !irq_request[irq_mask_pkg::BIT_BATTERY_OVERCURRENT])
    else $error("battery overcurrent request not masked");
  a_bat_voltage_gate: assert property (@(posedge clock) disable iff (reset)
    battery_undervoltage_mask |-> !irq_request[irq_mask_pkg::BIT_BATTERY_UNDERVOLTAGE])
    else $error("battery undervoltage request not masked");
  a_thermal_gate: assert property (@(posedge clock) disable iff (reset)
    !(thermistor_cold_mask && irq_request[irq_mask_pkg::BIT_THERMISTOR_COLD])
      && !(thermistor_cool_mask && irq_request[irq_mask_pkg::BIT_THERMISTOR_COOL])
      && !(thermistor_warm_mask && irq_request[irq_mask_pkg::BIT_THERMISTOR_WARM])
      && !(thermistor_hot_mask && irq_request[irq_mask_pkg::BIT_THERMISTOR_HOT]))
    else $error("thermistor zone request not masked");
  a_reserved_a_rw: assert property (@(posedge clock) disable iff (reset)
    (reg_write && reg_addr == irq_mask_pkg::ADDR_MASK_A)
      |=> reserved_a_bit == $past(reg_wdata[irq_mask_pkg::BIT_RESERVED_A]))
    else $error("first register reserved bit not writable");
  a_adc_gate: assert property (@(posedge clock) disable iff (reset)
    conversion_ready_mask
      |-> !irq_request[irq_mask_pkg::SRC_BASE_B + irq_mask_pkg::BIT_CONVERSION_READY])
    else $error("conversion ready request not masked");
  a_comparator_gate: assert property (@(posedge clock) disable iff (reset)
    !(comparator_one_alarm_mask
        && irq_request[irq_mask_pkg::SRC_BASE_B + irq_mask_pkg::BIT_COMPARATOR_ONE])
      && !(comparator_two_alarm_mask
        && irq_request[irq_mask_pkg::SRC_BASE_B + irq_mask_pkg::BIT_COMPARATOR_TWO])
      && !(comparator_three_alarm_mask
        && irq_request[irq_mask_pkg::SRC_BASE_B + irq_mask_pkg::BIT_COMPARATOR_THREE]))
    else $error("comparator alarm request not masked");
  a_open_gate: assert property (@(posedge clock) disable iff (reset)
    thermistor_open_mask
      |-> !irq_request[irq_mask_pkg::SRC_BASE_B + irq_mask_pkg::BIT_THERMISTOR_OPEN])
    else $error("thermistor open request not masked");
  a_reserved_b_rw: assert property (@(posedge clock) disable iff (reset)
    (reg_write && reg_addr == irq_mask_pkg::ADDR_MASK_B)
      |=> reserved_b_field == $past(reg_wdata[irq_mask_pkg::BIT_RESERVED_B_HI:
                                              irq_mask_pkg::BIT_RESERVED_B_LO]))
    else $error("second register reserved field not writable");
  a_reserved_c_rw: assert property (@(posedge clock) disable iff (reset)
    (reg_write && reg_addr == irq_mask_pkg::ADDR_MASK_C)
      |=> (reserved_c_hi_bit == $past(reg_wdata[irq_mask_pkg::BIT_RESERVED_C_HI])
        && reserved_c_lo_bit == $past(reg_wdata[irq_mask_pkg::BIT_RESERVED_C_LO])))
    else $error("third register reserved bits not writable");
  a_fault_c_gate: assert property (@(posedge clock) disable iff (reset)
    !(watchdog_fault_mask
        && irq_request[irq_mask_pkg::SRC_BASE_C + irq_mask_pkg::BIT_WATCHDOG_FAULT])
      && !(safety_timer_fault_mask
        && irq_request[irq_mask_pkg::SRC_BASE_C + irq_mask_pkg::BIT_SAFETY_TIMER_FAULT])
      && !(regulator_overcurrent_mask
        && irq_request[irq_mask_pkg::SRC_BASE_C + irq_mask_pkg::BIT_REGULATOR_OVERCURRENT]))
    else $error("third register fault request not masked");
  a_button_gate: assert property (@(posedge clock) disable iff (reset)
    !(button_wake_one_mask
        && irq_request[irq_mask_pkg::SRC_BASE_C + irq_mask_pkg::BIT_BUTTON_WAKE_ONE])
      && !(button_wake_two_mask
        && irq_request[irq_mask_pkg::SRC_BASE_C + irq_mask_pkg::BIT_BUTTON_WAKE_TWO])
      && !(button_reset_warning_mask
        && irq_request[irq_mask_pkg::SRC_BASE_C + irq_mask_pkg::BIT_BUTTON_RESET_WARNING]))
    else $error("button request not masked");
  a_flags_reset: assert property (@(posedge clock)
    reset |=> event_flags == 24'h00_0000)
    else $error("flags not cleared by reset");
  a_any_request: assert property (@(posedge clock) disable iff (reset)
    irq_any == (irq_request != 24'h00_0000))
    else $error("summary request wrong");

  // per source: set beats clear, clear works, unmasked flag passes
  for (genvar g = 0; g < $bits(event_in); g++) begin : g_source_checks
    a_flag_set: assert property (@(posedge clock) disable iff (reset)
      event_in[g] |=> event_flags[g])
      else $error("event flag not recorded");
    a_flag_clear: assert property (@(posedge clock) disable iff (reset)
      (flag_clear[g] && !event_in[g]) |=> !event_flags[g])
      else $error("event flag not cleared");
    a_unmasked_pass: assert property (@(posedge clock) disable iff (reset)
      (event_flags[g] && !mask_all[g]) |-> irq_request[g])
      else $error("unmasked request missing");
  end
endmodule : charger_interrupt_mask_bank

/* File: bench/host_model.sv */
// host side model: register writes and reads
`timescale 1ns/1ps
module host_model (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic            reg_write,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_write <= 1'b1;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    d = reg_rdata;
  endtask : rd
endmodule : host_model

/* File: bench/test_charger_interrupt_mask_bank.sv */
// bench for the charger interrupt mask bank
`timescale 1ns/1ps
module test_charger_interrupt_mask_bank;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_write, irq_any;
  logic [23:0] event_in = '0, flag_clear = '0, event_flags, irq_request, m;
  int          n_fail = 0, cmp_count = 0;
  initial forever #5 clock = ~clock;
  host_model host_model_inst (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  charger_interrupt_mask_bank charger_interrupt_mask_bank_inst (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .event_in(event_in), .flag_clear(flag_clear), .event_flags(event_flags),
    .irq_request(irq_request), .irq_any(irq_any));
  task automatic chk(input string s, input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_inst.rd(a, d);
    chk("reg_rdata", {16'h0000, d}, {16'h0000, exp});
  endtask : rd_chk
  task automatic test_regs;
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h71);
    rd_chk(8'h0a, 8'h00);
    host_model_inst.wr(8'h08, 8'h40);
    rd_chk(8'h08, 8'h40);
    host_model_inst.wr(8'h09, 8'h0e);
    rd_chk(8'h09, 8'h0e);
    host_model_inst.wr(8'h0a, 8'h88);
    rd_chk(8'h0a, 8'h88);
    host_model_inst.wr(8'h0b, 8'hff);
    rd_chk(8'h0b, 8'h00);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_gating;
    @(posedge clock);
    event_in <= '1;
    @(posedge clock);
    event_in <= '0;
    for (int i = 0; i < 24; i++) begin
      m = 24'h00_0001 << i;
      host_model_inst.wr(8'h08, m[7:0]);
      host_model_inst.wr(8'h09, m[15:8]);
      host_model_inst.wr(8'h0a, m[23:16]);
      @(posedge clock);
      chk("irq_request", irq_request, ~m);
      chk("event_flags", event_flags, 24'hff_ffff);
      chk("irq_any", {23'h0, irq_any}, 24'h00_0001);
    end
    flag_clear <= '1;
    @(posedge clock);
    flag_clear <= '0;
    @(posedge clock);
    chk("irq_any", {23'h0, irq_any}, 24'h0);
    chk("event_flags", event_flags, 24'h00_0000);
    $display("test_gating done");
  endtask : test_gating
  task automatic test_reset;
    host_model_inst.wr(8'h09, 8'h00);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h71);
    rd_chk(8'h0a, 8'h00);
    chk("event_flags", event_flags, 24'h00_0000);
    event_in <= '1;
    @(posedge clock);
    event_in <= '0;
    @(posedge clock);
    chk("irq_request", irq_request, 24'hff_8eff);
    event_in   <= 24'h00_0001;
    flag_clear <= '1;
    @(posedge clock);
    event_in   <= '0;
    flag_clear <= '0;
    @(posedge clock);
    chk("event_flags", event_flags, 24'h00_0001);
    flag_clear <= '1;
    @(posedge clock);
    flag_clear <= '0;
    $display("test_reset done");
  endtask : test_reset
  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    #50000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    test_regs;
    test_gating;
    test_reset;
    finish_test;
  end
endmodule : test_charger_interrupt_mask_bank
